// ==== logic/rcf_reset_cause_flags.sv ====
`include "rcf_defs.svh"
`default_nettype none

// ============================================================
// Reset cause flags with event interrupt
module rcf_reset_cause_flags (
   input wire logic clk,
   input wire logic resetn,
   input wire rcf_pkg::rcf_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire rcf_pkg::rcf_evt_t evt,
   input wire logic brownout_enable_cfg,
   output logic irq,
   output logic irq_priority_enable,
   output rcf_pkg::rcf_ctl_t ctl_flags
);

   // ============================================================
   // State and its next value
   rcf_pkg::rcf_state_t s_r; // Registered state
   rcf_pkg::rcf_state_t s_nxt; // Next state
   logic [5:0] ev_vec; // Events in status bit order
   logic [5:0] ist_nxt; // Next interrupt status
   logic wr_ctl; // Write hits control register
   logic wr_ist; // Write hits status register
   logic wr_imask; // Write hits mask register

   // ============================================================
   // Address decode
   assign wr_ctl = bus_req.wr && (bus_req.addr == `RCF_OFS_CTL);
   assign wr_ist = bus_req.wr && (bus_req.addr == `RCF_OFS_IST);
   assign wr_imask = bus_req.wr && (bus_req.addr == `RCF_OFS_IMASK);

   // ============================================================
   // Event vector; power-on counts in the first cycle after release
   assign ev_vec[`RCF_EV_POWERON] = !s_r.strap_done;
   assign ev_vec[`RCF_EV_BROWNOUT] = evt.brownout_rst;
   assign ev_vec[`RCF_EV_RESET_INSTR] = evt.reset_instr;
   assign ev_vec[`RCF_EV_TIMEOUT] = evt.wdt_timeout;
   assign ev_vec[`RCF_EV_SLEEP] = evt.sleep_instr;
   assign ev_vec[`RCF_EV_WDCLEAR] = evt.watchdog_clear_instr;

   // ============================================================
   // Sticky status per event: set wins over write-one-to-clear
   genvar gi;
   generate
      for (gi = 0; gi < `RCF_NUM_EV; gi = gi + 1) begin : g_ist
         assign ist_nxt[gi] = ev_vec[gi] |
            (s_r.ist[gi] & ~(wr_ist & bus_req.wdata[gi]));
      end
   endgenerate

   // ============================================================
   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      // Read data stands one cycle only, zero otherwise
      s_nxt.rdata = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            // Unimplemented bits already hold zero
            `RCF_OFS_CTL: begin
               s_nxt.rdata = s_r.ctl;
            end
            `RCF_OFS_IST: begin
               s_nxt.rdata = {2'h0, s_r.ist};
            end
            `RCF_OFS_IMASK: begin
               s_nxt.rdata = {2'h0, s_r.imask};
            end
            // Unmapped address reads zero
            default: begin
               s_nxt.rdata = 8'h00;
            end
         endcase
      end
      // Software write first, so hardware below overrides it
      if (wr_ctl) begin
         // Mask keeps bits 6..5 at zero
         s_nxt.ctl = bus_req.wdata & `RCF_CTL_WMASK;
      end
      if (wr_imask) begin
         s_nxt.imask = bus_req.wdata[5:0];
      end
      s_nxt.ist = ist_nxt;
      // Strap caught once after release, never under reset
      if (!s_r.strap_done) begin
         s_nxt.strap_done = 1'b1;
         s_nxt.ctl.brownout_flag = brownout_enable_cfg;
      end
      // Brown-out reset clears its flag
      if (evt.brownout_rst) begin
         s_nxt.ctl.brownout_flag = 1'b0;
      end
      // Reset instruction clears its flag
      if (evt.reset_instr) begin
         s_nxt.ctl.reset_instr_flag = 1'b0;
      end
      // Watchdog clear sets both time-out and power-down
      if (evt.watchdog_clear_instr) begin
         s_nxt.ctl.watchdog_timeout_flag = 1'b1;
         s_nxt.ctl.powerdown_flag = 1'b1;
      end
      // Sleep sets time-out, clears power-down
      if (evt.sleep_instr) begin
         s_nxt.ctl.watchdog_timeout_flag = 1'b1;
         s_nxt.ctl.powerdown_flag = 1'b0;
      end
      // Time-out is last: a real time-out must never be masked
      // by a clear or sleep in the same cycle
      if (evt.wdt_timeout) begin
         s_nxt.ctl.watchdog_timeout_flag = 1'b0;
      end
   end

   // ============================================================
   // State register; power-on reset loads constants only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         // Power-on flag clear means a power-on reset occurred
         s_r.ctl <= `RCF_CTL_RST;
         s_r.ist <= `RCF_IRQ_RST;
         s_r.imask <= `RCF_IRQ_RST;
         s_r.rdata <= 8'h00;
         s_r.strap_done <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ============================================================
   // Outputs
   assign rdata = s_r.rdata;
   // Level, high while any unmasked status bit is set
   assign irq = |(s_r.ist & s_r.imask);
   // One gives two priority levels, zero a single level
   assign irq_priority_enable = s_r.ctl.irq_priority_enable;
   assign ctl_flags = s_r.ctl;

   // ============================================================
   // Assertions
   // All run on clk and sleep while resetn is low, so the async
   // reset never trips them. Each one guards one or two flags, the control write, or a read, status or interrupt path;
   // simultaneous events are left to the priority order above,
   // and the antecedents exclude the combinations it overrides.
   // Brown-out reset must leave its flag clear
   a_bor_clear: assert property (@(posedge clk)
      disable iff (!resetn)
      evt.brownout_rst |=> !ctl_flags.brownout_flag)
      else $error("brown-out flag not cleared");

   // Only a software write may re-arm the brown-out flag
   a_bor_held: assert property (@(posedge clk)
      disable iff (!resetn)
      (!ctl_flags.brownout_flag && !wr_ctl && s_r.strap_done)
      |=> !ctl_flags.brownout_flag)
      else $error("brown-out flag rose without a write");

   // Strap capture copies the enable level into bit 0
   a_strap_bor: assert property (@(posedge clk)
      disable iff (!resetn)
      (!s_r.strap_done && !evt.brownout_rst)
      |=> ctl_flags.brownout_flag == $past(brownout_enable_cfg))
      else $error("brown-out flag does not follow enable");

   // Reset instruction must leave its flag clear
   a_ri_clear: assert property (@(posedge clk)
      disable iff (!resetn)
      evt.reset_instr |=> !ctl_flags.reset_instr_flag)
      else $error("reset instruction flag not cleared");

   // Time-out clears its flag even beside sleep or clear
   a_timeout_wins: assert property (@(posedge clk)
      disable iff (!resetn)
      evt.wdt_timeout |=> !ctl_flags.watchdog_timeout_flag)
      else $error("time-out flag not cleared");

   // Watchdog clear sets both time-out and power-down
   a_wdclear_sets: assert property (@(posedge clk)
      disable iff (!resetn)
      (evt.watchdog_clear_instr && !evt.wdt_timeout &&
       !evt.sleep_instr)
      |=> ctl_flags.watchdog_timeout_flag &&
          ctl_flags.powerdown_flag)
      else $error("watchdog clear did not set flags");

   // Sleep marks power-down and re-arms the time-out flag
   a_sleep_pd: assert property (@(posedge clk)
      disable iff (!resetn)
      (evt.sleep_instr && !evt.wdt_timeout)
      |=> !ctl_flags.powerdown_flag &&
          ctl_flags.watchdog_timeout_flag)
      else $error("sleep did not update flags");

   // Gap bits read back as zero
   a_unimpl_zero: assert property (@(posedge clk)
      disable iff (!resetn)
      (bus_req.rd && bus_req.addr == `RCF_OFS_CTL)
      |=> rdata[6:5] == 2'h0)
      else $error("unimplemented bits read nonzero");

   // Control read returns the value before the strobe edge
   a_read_ctl: assert property (@(posedge clk)
      disable iff (!resetn)
      (bus_req.rd && bus_req.addr == `RCF_OFS_CTL)
      |=> rdata == $past(ctl_flags))
      else $error("control read data wrong");

   // A quiet write lands on every implemented bit
   a_sw_write: assert property (@(posedge clk)
      disable iff (!resetn)
      (wr_ctl && s_r.strap_done && evt == '0)
      |=> ctl_flags == ($past(bus_req.wdata) & `RCF_CTL_WMASK))
      else $error("control write not stored");

   // Same-cycle reset instruction beats the software write
   a_hw_over_sw: assert property (@(posedge clk)
      disable iff (!resetn)
      (wr_ctl && evt.reset_instr)
      |=> !ctl_flags.reset_instr_flag)
      else $error("software write beat hardware");

   // Priority select follows the written bit 7
   a_prio_out: assert property (@(posedge clk)
      disable iff (!resetn)
      (wr_ctl && s_r.strap_done)
      |=> irq_priority_enable == $past(bus_req.wdata[7]))
      else $error("priority enable not written");

   // An unmasked time-out raises the interrupt next cycle
   a_irq_raise: assert property (@(posedge clk)
      disable iff (!resetn)
      (evt.wdt_timeout && s_r.imask[`RCF_EV_TIMEOUT] && !wr_imask)
      |=> irq)
      else $error("unmasked event gave no interrupt");

   // Sleep status bit survives every cycle without a clearing write
   a_ist_sticky: assert property (@(posedge clk)
      disable iff (!resetn)
      (s_r.ist[`RCF_EV_SLEEP] &&
       !(wr_ist && bus_req.wdata[`RCF_EV_SLEEP]))
      |=> s_r.ist[`RCF_EV_SLEEP] [*1])
      else $error("sticky status lost");

   // ============================================================
   // Assertions on held flags, status and read data
   // A flag that hardware clears must stay clear until software
   // rewrites it or a watchdog clear or sleep raises it, else the next event of that kind goes unseen.
   // Power-on image stands in the first cycle after release
   a_por_values: assert property (@(posedge clk)
      disable iff (!resetn)
      !s_r.strap_done |-> ctl_flags == `RCF_CTL_RST)
      else $error("power-on values wrong");

   // Hardware never sets the power-on flag; only software does
   a_por_held: assert property (@(posedge clk)
      disable iff (!resetn)
      (!ctl_flags.poweron_flag && !wr_ctl)
      |=> !ctl_flags.poweron_flag)
      else $error("power-on flag rose without a write");

   // Reset instruction flag stays clear until rewritten
   a_ri_held: assert property (@(posedge clk)
      disable iff (!resetn)
      (!ctl_flags.reset_instr_flag && !wr_ctl)
      |=> !ctl_flags.reset_instr_flag)
      else $error("reset instruction flag rose alone");

   // Time-out flag only rises by clear, sleep or write
   a_to_held: assert property (@(posedge clk)
      disable iff (!resetn)
      (!ctl_flags.watchdog_timeout_flag && !wr_ctl &&
       !evt.watchdog_clear_instr && !evt.sleep_instr)
      |=> !ctl_flags.watchdog_timeout_flag)
      else $error("time-out flag rose alone");

   // Power-down flag only rises by clear or write
   a_pd_held: assert property (@(posedge clk)
      disable iff (!resetn)
      (!ctl_flags.powerdown_flag && !wr_ctl &&
       !evt.watchdog_clear_instr)
      |=> !ctl_flags.powerdown_flag)
      else $error("power-down flag rose alone");

   // Gap bits never hold anything but zero
   a_unimpl_state: assert property (@(posedge clk)
      disable iff (!resetn)
      ctl_flags.unimpl == 2'h0)
      else $error("unimplemented bits hold nonzero");

   // Priority select moves only on a control write
   a_prio_hold: assert property (@(posedge clk)
      disable iff (!resetn)
      !wr_ctl |=> $stable(irq_priority_enable))
      else $error("priority enable moved without a write");

   // Read data stand one cycle only, zero when no read
   a_rdata_idle: assert property (@(posedge clk)
      disable iff (!resetn)
      !bus_req.rd |=> rdata == 8'h00)
      else $error("read data without a read");

   // Status read returns the value before the strobe edge
   a_read_ist: assert property (@(posedge clk)
      disable iff (!resetn)
      (bus_req.rd && bus_req.addr == `RCF_OFS_IST)
      |=> rdata == {2'h0, $past(s_r.ist)})
      else $error("status read data wrong");

   // Every event leaves its status bit set
   a_ist_set: assert property (@(posedge clk)
      disable iff (!resetn)
      (ev_vec != 6'h00)
      |=> (s_r.ist & $past(ev_vec)) == $past(ev_vec))
      else $error("event not latched in status");

   // Write one clears a status bit when no event sets it
   a_ist_w1c: assert property (@(posedge clk)
      disable iff (!resetn)
      (wr_ist && bus_req.wdata[`RCF_EV_TIMEOUT] && !evt.wdt_timeout)
      |=> !s_r.ist[`RCF_EV_TIMEOUT])
      else $error("status bit not cleared by write");

   // Mask write lands on the six event bits
   a_imask_write: assert property (@(posedge clk)
      disable iff (!resetn)
      wr_imask |=> s_r.imask == $past(bus_req.wdata[5:0]))
      else $error("mask write not stored");

endmodule // rcf_reset_cause_flags
`default_nettype wire

// ==== inc/rcf_defs.svh ====
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
// ============================================================
// Register offsets on the plain register port
`define RCF_OFS_CTL 8'h00
`define RCF_OFS_IST 8'h04
`define RCF_OFS_IMASK 8'h08
// ============================================================
// Reset cause control field positions
`define RCF_BIT_BOR 0
`define RCF_BIT_POR 1
`define RCF_BIT_PD 2
`define RCF_BIT_TO 3
`define RCF_BIT_RI 4
`define RCF_BIT_IRQ_PRIORITY_ENABLE 7
// Implemented, software writable bits (bits 6..5 excluded)
`define RCF_CTL_WMASK 8'h9f
// Power-on value: ri, to, pd set; all else clear
`define RCF_CTL_RST 8'h1c
// ============================================================
// Interrupt status bit positions, one per event
`define RCF_NUM_EV 6
`define RCF_EV_POWERON 0
`define RCF_EV_BROWNOUT 1
`define RCF_EV_RESET_INSTR 2
`define RCF_EV_TIMEOUT 3
`define RCF_EV_SLEEP 4
`define RCF_EV_WDCLEAR 5
`define RCF_IRQ_RST 6'h00
`endif

// ==== inc/rcf_pkg.sv ====
`default_nettype none
package rcf_pkg;
   // ============================================================
   // Reset cause control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic irq_priority_enable;
      logic [1:0] unimpl;
      logic reset_instr_flag;
      logic watchdog_timeout_flag;
      logic powerdown_flag;
      logic poweron_flag;
      logic brownout_flag;
   } rcf_ctl_t;
   // ============================================================
   // Core events, each a one-cycle pulse on clk
   typedef struct packed {
      logic brownout_rst;
      logic reset_instr;
      logic wdt_timeout;
      logic sleep_instr;
      logic watchdog_clear_instr;
   } rcf_evt_t;
   // ============================================================
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rcf_bus_req_t;
   // ============================================================
   // Whole state of the block
   typedef struct packed {
      rcf_ctl_t ctl;
      logic [5:0] ist;
      logic [5:0] imask;
      logic [7:0] rdata;
      logic strap_done;
   } rcf_state_t;
endpackage
`default_nettype wire

// ==== testbench/rcf_testbench.sv ====
`include "rcf_defs.svh"
`default_nettype none
// ============================================================
// Compare helper: counts each check, reports a mismatch at once
`define RCF_CHK(nm, ex, got) begin \
   tests_run++; \
   if ((got) !== (ex)) begin \
      failures++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
   end \
end

// ============================================================
// Self-checking bench for the reset cause flags
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0; // Core clock, 4 ns period
   logic resetn; // Power-on reset; its first low drive is a real edge
   rcf_pkg::rcf_bus_req_t bus_req = '0; // Register port request
   rcf_pkg::rcf_evt_t evt = '0; // Core event pulses
   logic brownout_enable_cfg = 1'b1; // Static config level
   logic [7:0] rdata;
   logic irq;
   logic irq_priority_enable;
   rcf_pkg::rcf_ctl_t ctl_flags;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0; // Hang guard
   // Event pulses and the flags expected after each, from 8'h9f
   // Last entry: time-out with sleep, time-out clear must win
   rcf_pkg::rcf_evt_t ev_tab [6] = '{5'h10, 5'h08, 5'h04, 5'h02,
      5'h01, 5'h06};
   logic [7:0] ev_exp [6] = '{8'h9e, 8'h8e, 8'h86, 8'h8a, 8'h8e,
      8'h82};

   rcf_reset_cause_flags u_dut (
      .clk(clk),
      .resetn(resetn),
      .bus_req(bus_req),
      .rdata(rdata),
      .evt(evt),
      .brownout_enable_cfg(brownout_enable_cfg),
      .irq(irq),
      .irq_priority_enable(irq_priority_enable),
      .ctl_flags(ctl_flags)
   );

   // Free-running clock
   always #2 clk = ~clk;

   // Cut a hang short; the whole run needs under a hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         print_verdict();
      end
   end

   // ============================================================
   // Bus and event drivers
   // One request cycle; strobes and events drop after one edge
   task automatic cyc(input logic wr, input logic rd,
      input logic [7:0] a, input logic [7:0] d,
      input rcf_pkg::rcf_evt_t e);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: wr, rd: rd};
      evt <= e;
      @(posedge clk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
      evt <= '0;
      #1; // Let the edge's updates land before sampling
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b1, 1'b0, a, d, '0);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex,
      input string nm);
      cyc(1'b0, 1'b1, a, 8'h00, '0);
      `RCF_CHK(nm, ex, rdata)
   endtask

   // Power-on reset held 11 cycles, then the strap is captured
   task automatic do_reset(input logic cfg);
      @(posedge clk);
      resetn <= 1'b0;
      brownout_enable_cfg <= cfg;
      repeat (10) @(posedge clk);
      #1;
      `RCF_CHK("ctl in reset", 8'h1c, ctl_flags)
      `RCF_CHK("irq in reset", 1'b0, irq)
      `RCF_CHK("rdata in reset", 8'h00, rdata)
      `RCF_CHK("priority in reset", 1'b0, irq_priority_enable)
      @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      `RCF_CHK("ctl after reset", {7'h0e, cfg}, ctl_flags)
   endtask

   // Single exit point of the run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ============================================================
   // Main sequence
   initial begin
      do_reset(1'b1);
      rd_chk(`RCF_OFS_CTL, 8'h1d, "ctl power-on");
      @(posedge clk);
      #1;
      `RCF_CHK("rdata idle", 8'h00, rdata)
      // All ones: unimplemented bits must stay clear
      wr(`RCF_OFS_CTL, 8'hff);
      rd_chk(`RCF_OFS_CTL, 8'h9f, "ctl all ones");
      `RCF_CHK("priority on", 1'b1, irq_priority_enable)
      wr(`RCF_OFS_CTL, 8'h60);
      rd_chk(`RCF_OFS_CTL, 8'h00, "ctl gap bits");
      `RCF_CHK("priority off", 1'b0, irq_priority_enable)
      // Re-arm every flag, then walk each event kind
      wr(`RCF_OFS_CTL, 8'h9f);
      for (int i = 0; i < 6; i++) begin
         cyc(1'b0, 1'b0, 8'h00, 8'h00, ev_tab[i]);
         `RCF_CHK("ctl event", ev_exp[i], ctl_flags)
      end
      // Write and brown-out in one cycle: hardware keeps bit 0
      cyc(1'b1, 1'b0, `RCF_OFS_CTL, 8'hff, 5'h10);
      `RCF_CHK("write vs event", 8'h9e, ctl_flags)
      // Write and reset instruction in one cycle: hardware keeps bit 4
      cyc(1'b1, 1'b0, `RCF_OFS_CTL, 8'hff, 5'h08);
      `RCF_CHK("write vs reset instr", 8'h8f, ctl_flags)
      // Sleep and watchdog clear together: power-down ends clear
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 5'h03);
      `RCF_CHK("sleep with clear", 8'h8b, ctl_flags)
      // Interrupt: every event latched, masked, then cleared
      rd_chk(`RCF_OFS_IST, 8'h3f, "status all");
      `RCF_CHK("irq masked", 1'b0, irq)
      wr(`RCF_OFS_IMASK, 8'h08);
      `RCF_CHK("irq unmasked", 1'b1, irq)
      rd_chk(`RCF_OFS_IMASK, 8'h08, "mask read");
      wr(`RCF_OFS_IST, 8'h08);
      rd_chk(`RCF_OFS_IST, 8'h37, "status w1c");
      `RCF_CHK("irq cleared", 1'b0, irq)
      wr(`RCF_OFS_IMASK, 8'hff);
      `RCF_CHK("irq all", 1'b1, irq)
      wr(`RCF_OFS_IST, 8'hff);
      `RCF_CHK("irq none", 1'b0, irq)
      rd_chk(`RCF_OFS_IST, 8'h00, "status empty");
      // Unmapped place: reads zero, write lands nowhere
      rd_chk(8'h0c, 8'h00, "unmapped read");
      wr(8'h0c, 8'hff);
      rd_chk(`RCF_OFS_CTL, 8'h8b, "ctl untouched");
      // Second power-on with brown-out detection off
      do_reset(1'b0);
      rd_chk(`RCF_OFS_CTL, 8'h1c, "ctl no brown-out");
      rd_chk(`RCF_OFS_IST, 8'h01, "status power-on");
      rd_chk(`RCF_OFS_IMASK, 8'h00, "mask reset");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
